//--- logic/mtw_mark_track_window.sv
`timescale 1ns/1ps
`default_nettype none
module mtw_mark_track_window #(
  parameter int unsigned WR_CLK_DIV = mtw_pkg::WR_CLK_DIV_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_timing_track_rd,
  input wire logic i_mark_track_rd_p,
  input wire logic i_mark_track_rd_n,
  input wire logic i_transport_start,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output mtw_pkg::mtw_pulses_s o_pulses,
  output mtw_pkg::mtw_writers_s o_writers,
  output logic o_writers_enable,
  output logic o_mode_lamp,
  output logic o_mark_match
);
  import mtw_pkg::*;

  localparam int unsigned DLY_W = $clog2(MARK_CHECK_DELAY_CYC + 1);
  localparam int unsigned DIV_W = $clog2(WR_CLK_DIV + 1);

  // Synchronisers
  logic [1:0] tt_sync_q;
  logic [1:0] mp_sync_q;
  logic [1:0] mn_sync_q;
  logic tt_last_q;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tt_sync_q <= 2'h0;
      mp_sync_q <= 2'h0;
      mn_sync_q <= 2'h0;
      tt_last_q <= 1'b0;
    end
    else
    begin
      tt_sync_q <= {tt_sync_q[0], i_timing_track_rd};
      mp_sync_q <= {mp_sync_q[0], i_mark_track_rd_p};
      mn_sync_q <= {mn_sync_q[0], i_mark_track_rd_n};
      tt_last_q <= tt_sync_q[1];
    end
  end

  // Control registers
  logic [4:0] ctrl_q;
  logic [7:0] pattern_q;
  logic [7:0] match_en_q;
  wire mode = ctrl_q[CTRL_MODE_BIT];
  wire ext_match = ctrl_q[CTRL_EXT_BIT];

  wire tt_fall = tt_last_q & ~tt_sync_q[1];
  wire tt_rise = ~tt_last_q & tt_sync_q[1];

  // Local write clock divider
  logic [DIV_W-1:0] div_q;
  logic [1:0] gray_q;
  mtw_gray_e gstate_q;
  // local clock runs only in mode
  wire div_tick = mode && (div_q == DIV_W'(WR_CLK_DIV - 1));
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      div_q <= '0;
    else if (!mode || div_tick)
      div_q <= '0;
    else
      div_q <= div_q + DIV_W'(1);
  end

  // gray counter stepped by local clock
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      gstate_q <= GRAY_00;
    else if (!mode)
      gstate_q <= GRAY_00;
    else if (div_tick)
    begin
      case (gstate_q)
        GRAY_00: gstate_q <= GRAY_01;
        GRAY_01: gstate_q <= GRAY_11;
        GRAY_11: gstate_q <= GRAY_10;
        GRAY_10: gstate_q <= GRAY_00;
        default: gstate_q <= GRAY_00;
      endcase
    end
  end
  always_comb
  begin
    case (gstate_q)
      GRAY_00: gray_q = 2'b00;
      GRAY_01: gray_q = 2'b01;
      GRAY_11: gray_q = 2'b11;
      GRAY_10: gray_q = 2'b10;
      default: gray_q = 2'b00;
    endcase
  end

  wire loc_strobe = div_tick && (gstate_q == GRAY_01);
  wire loc_between = div_tick && (gstate_q == GRAY_10);
  wire bit_strobe = mode ? loc_strobe : tt_fall;
  wire between_bit = mode ? loc_between : tt_rise;

  logic [DLY_W-1:0] dly_q;
  logic dly_run_q;
  wire dly_done = dly_run_q && (dly_q == DLY_W'(MARK_CHECK_DELAY_CYC - 1));
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dly_q <= '0;
      dly_run_q <= 1'b0;
    end
    else if (bit_strobe)
    begin
      dly_q <= '0;
      dly_run_q <= 1'b1;
    end
    else if (dly_done)
      dly_run_q <= 1'b0;
    else if (dly_run_q)
      dly_q <= dly_q + DLY_W'(1);
  end

  // Pulse outputs registered
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_pulses <= '0;
    else
    begin
      o_pulses.bit_strobe <= bit_strobe;
      o_pulses.between_bit <= between_bit;
      o_pulses.mark_check <= dly_done;
    end
  end

  // Writers
  logic write_ff_q;
  logic mark_wr_q;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      write_ff_q <= 1'b0;
      mark_wr_q <= 1'b0;
    end
    else
    begin
      if (bit_strobe)
        write_ff_q <= ~write_ff_q ^ ctrl_q[CTRL_WDATA_BIT];
      if (between_bit)
        mark_wr_q <= ctrl_q[CTRL_MARK_WBIT];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_writers <= '0;
      o_writers_enable <= 1'b0;
      o_mode_lamp <= 1'b0;
    end
    else
    begin
      // timing writer follows gray bit in quadrature
      o_writers.timing_track <= mode & gray_q[1];
      o_writers.mark_track <= mark_wr_q;
      o_writers.data <= write_ff_q;
      o_writers_enable <= mode;
      o_mode_lamp <= mode;
    end
  end

  logic mark_bit_q;
  logic mark_valid_q;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mark_bit_q <= 1'b0;
      mark_valid_q <= 1'b0;
    end
    else if (bit_strobe)
    begin
      mark_bit_q <= mp_sync_q[1] & ~mn_sync_q[1];
      mark_valid_q <= mp_sync_q[1] ^ mn_sync_q[1];
    end
  end

  // Window register plus qualifier
  logic [7:0] window_q;
  logic qual_q;
  logic strobe_d1_q;
  logic start_last_q;
  logic [1:0] start_sync_q;
  wire start_rise = start_sync_q[1] & ~start_last_q;
  logic sw_clear;
  wire clear_window = sw_clear | start_rise;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      strobe_d1_q <= 1'b0;
      start_sync_q <= 2'h0;
      start_last_q <= 1'b0;
    end
    else
    begin
      strobe_d1_q <= bit_strobe;
      start_sync_q <= {start_sync_q[0], i_transport_start};
      start_last_q <= start_sync_q[1];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      window_q <= 8'h00;
      qual_q <= 1'b0;
    end
    else if (clear_window)
    begin
      window_q <= 8'h00;
      qual_q <= 1'b0;
    end
    else if (strobe_d1_q && !mode)
    begin
      window_q <= {window_q[6:0], mark_bit_q};
      // qualifier set only from bit eight
      if (window_q[7])
        qual_q <= 1'b1;
    end
  end

  wire [7:0] cmp_mask = ext_match ? 8'hFF : 8'h3F;
  wire pattern_hit = ((window_q ^ pattern_q) & cmp_mask & match_en_q) == 8'h00;
  wire detect = qual_q & pattern_hit;

  logic match_q;
  logic match_sticky_q;
  logic clr_match;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      match_q <= 1'b0;
    else if (dly_done)
      match_q <= detect;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      match_sticky_q <= 1'b0;
    else if (dly_done && detect)
      match_sticky_q <= 1'b1;
    else if (clr_match)
      match_sticky_q <= 1'b0;
  end
  assign o_mark_match = match_q;

  // AXI4-Lite slave
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign o_s_axi_awready = !aw_got_q && !bvalid_q;
  assign o_s_axi_wready = !w_got_q && !bvalid_q;
  assign o_s_axi_arready = !rvalid_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  wire aw_hs = i_s_axi_awvalid && o_s_axi_awready;
  wire w_hs = i_s_axi_wvalid && o_s_axi_wready;
  wire have_aw = aw_got_q || aw_hs;
  wire have_w = w_got_q || w_hs;
  wire do_write = have_aw && have_w;
  wire [7:0] wa = aw_got_q ? awaddr_q : i_s_axi_awaddr[7:0];
  wire [31:0] wd = w_got_q ? wdata_q : i_s_axi_wdata;
  wire wr_hi_ok = aw_got_q ? 1'b1 : (i_s_axi_awaddr[31:8] == 24'h000000);
  wire wr_ctrl = do_write && wr_hi_ok && (wa == REG_CTRL);
  wire wr_pat = do_write && wr_hi_ok && (wa == REG_PATTERN);
  wire wr_mask = do_write && wr_hi_ok && (wa == REG_MATCH);
  wire wr_stat = do_write && wr_hi_ok && (wa == REG_STATUS);
  wire wr_ok = wr_ctrl | wr_pat | wr_mask | wr_stat;
  assign sw_clear = wr_ctrl && wd[CTRL_CLEAR_BIT];
  assign clr_match = wr_stat && wd[0];
  wire ar_hs = i_s_axi_arvalid && o_s_axi_arready;
  wire [7:0] ra = i_s_axi_araddr[7:0];
  wire rd_hi_ok = i_s_axi_araddr[31:8] == 24'h000000;
  wire rd_ctrl = rd_hi_ok && (ra == REG_CTRL);
  wire rd_stat = rd_hi_ok && (ra == REG_STATUS);
  wire rd_win = rd_hi_ok && (ra == REG_WINDOW);
  wire rd_pat = rd_hi_ok && (ra == REG_PATTERN);
  wire rd_mask = rd_hi_ok && (ra == REG_MATCH);
  wire rd_ok = rd_ctrl | rd_stat | rd_win | rd_pat | rd_mask;
  wire [31:0] status_word = {27'h0, mark_valid_q, mode, qual_q, match_q, match_sticky_q};
  wire [31:0] rd_word = rd_ctrl ? {27'h0, ctrl_q & 5'h1D} :
                        rd_stat ? status_word :
                        rd_win ? {23'h0, qual_q, window_q} :
                        rd_pat ? {24'h0, pattern_q} :
                        rd_mask ? {24'h0, match_en_q} : 32'h00000000;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else
      begin
        if (aw_hs)
        begin
          aw_got_q <= 1'b1;
          awaddr_q <= (i_s_axi_awaddr[31:8] == 24'h000000) ? i_s_axi_awaddr[7:0] : 8'hFF;
        end
        if (w_hs)
        begin
          w_got_q <= 1'b1;
          wdata_q <= i_s_axi_wdata;
        end
        if (bvalid_q && i_s_axi_bready)
          bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= AXI_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end
    else if (rvalid_q && i_s_axi_rready)
      rvalid_q <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_q <= CTRL_RESET;
      pattern_q <= PATTERN_RESET;
      match_en_q <= 8'hFF;
    end
    else
    begin
      if (wr_ctrl && i_s_axi_wstrb[0])
        ctrl_q <= wd[4:0] & 5'h1D;
      if (wr_pat && i_s_axi_wstrb[0])
        pattern_q <= wd[7:0];
      if (wr_mask && i_s_axi_wstrb[0])
        match_en_q <= wd[7:0];
    end
  end
endmodule
`default_nettype wire

//--- include/mtw_pkg.sv
package mtw_pkg;
  // Timing figures
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned MARK_CHECK_DELAY_NS = 4500;
  localparam int unsigned MARK_CHECK_DELAY_CYC = (MARK_CHECK_DELAY_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned BIT_PERIOD_NS = 33000;
  localparam int unsigned BIT_PERIOD_CYC = (BIT_PERIOD_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned WR_CLK_DIV_DEFAULT = BIT_PERIOD_CYC / 2;

  // Register map (byte offsets)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WINDOW = 8'h08;
  localparam logic [7:0] REG_PATTERN = 8'h0C;
  localparam logic [7:0] REG_MATCH = 8'h10;

  // Control field positions
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned CTRL_WDATA_BIT = 2;
  localparam int unsigned CTRL_MARK_WBIT = 3;
  localparam int unsigned CTRL_EXT_BIT = 4;

  // Reset values and AXI response codes
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic bit_strobe;
    logic between_bit;
    logic mark_check;
  } mtw_pulses_s;

  typedef struct packed {
    logic timing_track;
    logic mark_track;
    logic data;
  } mtw_writers_s;

  typedef enum logic [3:0] {
    GRAY_00 = 4'b0001,
    GRAY_01 = 4'b0010,
    GRAY_11 = 4'b0100,
    GRAY_10 = 4'b1000
  } mtw_gray_e;
endpackage

//--- tb/mtw_window_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mtw_window_properties #(
  parameter int unsigned WR_CLK_DIV = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_timing_track_rd,
  input wire logic i_s_axi_bready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic i_s_axi_rready,
  input wire logic o_s_axi_rvalid,
  input wire logic [31:0] o_s_axi_rdata,
  input wire mtw_pkg::mtw_pulses_s o_pulses,
  input wire logic o_writers_enable,
  input wire logic o_mode_lamp,
  input wire logic o_mark_match
);
  import mtw_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  a_strobe_fall: assert property (
    $fell(i_timing_track_rd) && !o_mode_lamp |-> ##[2:5] o_pulses.bit_strobe)
    else $error("no bit strobe after timing fall");
  a_between_rise: assert property (
    $rose(i_timing_track_rd) && !o_mode_lamp |-> ##[2:5] o_pulses.between_bit)
    else $error("no between-bit pulse after timing rise");
  a_check_delay: assert property (
    o_pulses.mark_check |-> $past(o_pulses.bit_strobe, 449) ||
      $past(o_pulses.bit_strobe, 450) || $past(o_pulses.bit_strobe, 451))
    else $error("mark check without earlier strobe");
  a_lamp_follow: assert property (
    o_mode_lamp == o_writers_enable)
    else $error("lamp and writer enable differ");
  a_local_quad: assert property (
    o_mode_lamp && o_pulses.bit_strobe |=> (!o_pulses.between_bit) [*7])
    else $error("between-bit too close to local strobe");
  a_match_at_check: assert property (
    $rose(o_mark_match) |-> o_pulses.mark_check)
    else $error("match rose outside mark check");
  a_bvalid_hold: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read response dropped or changed");
  a_read_resp: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
endmodule
bind mtw_mark_track_window mtw_window_properties #(.WR_CLK_DIV(WR_CLK_DIV)) u_props (
  .i_sys_clk, .i_rst, .i_timing_track_rd, .i_s_axi_bready, .o_s_axi_bvalid,
  .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_rready, .o_s_axi_rvalid, .o_s_axi_rdata,
  .o_pulses, .o_writers_enable, .o_mode_lamp, .o_mark_match);
`default_nettype wire

//--- tb/mtw_tape_model.sv
`timescale 1ns/1ps
`default_nettype none
module mtw_tape_model (
  output logic o_timing_track,
  output logic o_mark_p,
  output logic o_mark_n
);
  initial
  begin
    o_timing_track = 1'b0;
    o_mark_p = 1'b0;
    o_mark_n = 1'b0;
  end
  task automatic send_bit(input logic b);
    #3;
    o_timing_track = 1'b1;
    o_mark_p = b;
    o_mark_n = ~b;
    #40;
    o_timing_track = 1'b0;
    #37;
  endtask
  // Released amplifier shows equal lines
  task automatic release_mark();
    o_mark_p = ~o_mark_p;
    o_mark_n = o_mark_p;
  endtask
endmodule
`default_nettype wire

//--- tb/mtw_mark_track_window_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mtw_mark_track_window_bench;
  import mtw_pkg::*;
  logic i_sys_clk, i_rst, i_transport_start, i_s_axi_awvalid, i_s_axi_wvalid;
  logic i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
  logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, o_s_axi_rdata, b;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic i_timing_track_rd, i_mark_track_rd_p, i_mark_track_rd_n;
  logic o_writers_enable, o_mode_lamp, o_mark_match;
  mtw_pulses_s o_pulses;
  mtw_writers_s o_writers;
  int failures, comparisons, win, qual, mode, k, x, p, cnt;
  always #5 i_sys_clk = ~i_sys_clk;
  mtw_tape_model u_tape (.o_timing_track(i_timing_track_rd), .o_mark_p(i_mark_track_rd_p),
    .o_mark_n(i_mark_track_rd_n));
  mtw_mark_track_window #(.WR_CLK_DIV(4)) u_mtw_mark_track_window (.i_sys_clk, .i_rst,
    .i_timing_track_rd, .i_mark_track_rd_p, .i_mark_track_rd_n, .i_transport_start,
    .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
    .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
    .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
    .o_s_axi_rvalid, .i_s_axi_rready, .o_pulses, .o_writers, .o_writers_enable,
    .o_mode_lamp, .o_mark_match);
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 100)
    begin
      failures++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    i_s_axi_awaddr <= {24'h0, a};
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge i_sys_clk);
      if (o_s_axi_awready === 1'b1) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready === 1'b1) i_s_axi_wvalid <= 1'b0;
      if (i_s_axi_bready && o_s_axi_bvalid === 1'b1) break;
      if (o_s_axi_bvalid === 1'b1) i_s_axi_bready <= 1'b1;
    end
    i_s_axi_bready <= 1'b0;
    check({30'h0, o_s_axi_bresp}, 32'h0);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    i_s_axi_araddr <= {24'h0, a};
    i_s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge i_sys_clk);
      if (o_s_axi_arready === 1'b1) i_s_axi_arvalid <= 1'b0;
      if (i_s_axi_rready && o_s_axi_rvalid === 1'b1) break;
      if (o_s_axi_rvalid === 1'b1) i_s_axi_rready <= 1'b1;
    end
    i_s_axi_rready <= 1'b0;
    check(o_s_axi_rdata, e);
    check({30'h0, o_s_axi_rresp}, {30'h0, r});
    tmo(n);
  endtask
  task automatic play(input int n, input logic [31:0] bits);
    int i;
    for (i = 0; i < n; i++)
    begin
      u_tape.send_bit(bits[i]);
      if (mode == 0)
      begin
        qual = qual | ((win >> 7) & 1);
        win = ((win << 1) | int'(bits[i])) & 255;
      end
    end
    u_tape.release_mark();
    repeat (10) @(posedge i_sys_clk);
  endtask
  initial
  begin
    i_sys_clk = 1'b0;
    i_rst = 1'b1;
    {i_transport_start, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 4'h0;
    {i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
    {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr} = 96'h0;
    i_s_axi_wstrb = 4'hF;
    {failures, comparisons, win, qual, mode} = 160'h0;
    void'($urandom(32'hDACE));
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    rd(REG_CTRL, 32'h0, AXI_OKAY);
    rd(REG_PATTERN, 32'h0, AXI_OKAY);
    rd(REG_MATCH, 32'hFF, AXI_OKAY);
    rd(8'h14, 32'h0, AXI_SLVERR);
    play(20, $urandom | 32'h1);
    rd(REG_WINDOW, 32'(qual * 256 + win), AXI_OKAY);
    for (k = 0; k < 4; k++)
    begin
      if (k == 3)
      begin
        wr(REG_CTRL, 32'h12);
        win = 0;
        qual = 0;
        rd(REG_CTRL, 32'h10, AXI_OKAY);
        rd(REG_WINDOW, 32'h0, AXI_OKAY);
      end
      wr(REG_CTRL, (k == 1) ? 32'h0 : 32'h10);
      b = $urandom;
      p = win;
      for (cnt = 0; cnt < 8; cnt++) p = ((p << 1) | int'(b[cnt])) & 255;
      x = (k == 2) ? 128 : 0;
      wr(REG_PATTERN, 32'(p ^ x));
      play(8, b);
      repeat (500) @(posedge i_sys_clk);
      check({31'h0, o_mark_match}, 32'(qual == 1 && win == (p ^ x)));
    end
    i_transport_start <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    i_transport_start <= 1'b0;
    win = 0;
    qual = 0;
    rd(REG_WINDOW, 32'h0, AXI_OKAY);
    wr(REG_CTRL, 32'h1);
    mode = 1;
    repeat (2) @(posedge i_sys_clk);
    check({31'h0, o_mode_lamp}, 32'h1);
    check({31'h0, o_writers_enable}, 32'h1);
    cnt = 0;
    x = 0;
    repeat (160)
    begin
      @(posedge i_sys_clk);
      if (o_pulses.bit_strobe === 1'b1) cnt++;
      if (o_writers.timing_track === 1'b1) x++;
    end
    check(32'(cnt >= 9 && cnt <= 11), 32'h1);
    check(32'(x >= 78 && x <= 82), 32'h1);
    play(8, $urandom);
    rd(REG_WINDOW, 32'(qual * 256 + win), AXI_OKAY);
    wr(REG_CTRL, 32'h0);
    mode = 0;
    repeat (2) @(posedge i_sys_clk);
    check({31'h0, o_mode_lamp}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
